// [src/lcc_config.sv]
`timescale 1ns/100ps
module lcc_config
    import lcc_pkg::*;
#(
    parameter logic ROWS80 = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        init_pulse_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ram_wr,
    input  wire logic [6:0]  ram_col_in,
    output logic      [6:0]  ram_col_out,
    output logic             outputs_low,
    output logic             generators_on,
    output logic             oscillator_on,
    output logic             inverse_out,
    output logic             all_on_out,
    output logic      [2:0]  mult_factor,
    output logic      [1:0]  picture_rate_sel,
    output logic      [2:0]  temp_slope_sel,
    output logic      [2:0]  rows_at_once,
    output logic             ext_clock_sel
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lcc_state_t  state;
    logic [4:0]  cnt;
    logic        display_on_bit;
    logic        inverse_bit;
    logic        all_pixels_on_bit;
    logic        column_flip;
    logic        row_flip;
    logic        ext_set;
    logic        sleep_state;
    logic        clock_source_run;
    logic [1:0]  mult_basic;
    logic [2:0]  mult_ext;
    logic [5:0]  vlcd_level_code;
    logic [2:0]  vlcd_level_shift;
    logic        vert_addr;
    logic        byte_flip_sel;
    logic        symbol_line_en;
    logic        lower_lines_flip;
    logic        row_group_sel;
    logic        init_n_q;
    logic        soft_reset;
    logic        cfg_clear;
    logic        acc;
    logic        wr_ok;
    logic        wr_disp;
    logic        wr_pow;
    logic        wr_ext;
    lcc_mode_t   mode;
    logic        busy;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] lcc_mult(input logic ext,
                                            input logic [1:0] b,
                                            input logic [2:0] e);
        // Returns multiplication factor as a number
        logic [2:0] r;
        r = 3'h0;
        if (ext) begin
            // Upper half of the code repeats the basic range
            case (e[2])
                1'b1:    r = 3'(e[1:0]) + 3'h4;
                default: r = 3'(e[1:0]) + 3'h2;
            endcase
        end else begin
            r = 3'(b) + 3'h4;
        end
        return r;
    endfunction

    function automatic logic lcc_drives(input lcc_mode_t m);
        // Pads and generators run only in a visible mode
        return (m == LCC_DM_NORMAL) || (m == LCC_DM_INVERSE)
               || (m == LCC_DM_ALL_ON);
    endfunction

    // ------------------------------------------------------------
    // Bus slave: one wait cycle per access, busy refuses writes
    // ------------------------------------------------------------
    // Busy-window writes are acked but dropped, so a host that
    // skips the status poll loses them without any error
    assign busy    = (state != LCC_IDLE);
    assign acc     = (avs_read | avs_write) & avs_waitrequest;
    assign wr_ok   = avs_write & !avs_waitrequest & !busy;
    assign wr_disp = wr_ok & (avs_address == LCC_OFF_DISPLAY);
    assign wr_pow  = wr_ok & (avs_address == LCC_OFF_POWER);
    assign wr_ext  = wr_ok & (avs_address == LCC_OFF_EXT);
    assign soft_reset = wr_disp & avs_byteenable[0]
                        & avs_writedata[LCC_DS_RESET];
    assign cfg_clear  = !init_n_q | soft_reset;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !acc;
        end
    end

    // ------------------------------------------------------------
    // Init sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_n_q <= 1'b1;
            state    <= LCC_INIT;
            cnt      <= LCC_INIT_CYC;
        end else begin
            init_n_q <= init_pulse_n;
            case (state)
                LCC_IDLE: begin
                    if (cfg_clear) begin
                        state <= LCC_INIT;
                        cnt   <= LCC_INIT_CYC;
                    end else if (wr_ok) begin
                        state <= LCC_BUSY;
                        cnt   <= 5'(LCC_BUSY_CYC);
                    end
                end
                LCC_INIT, LCC_BUSY: begin
                    if (!init_n_q) begin
                        state <= LCC_INIT;
                        cnt   <= LCC_INIT_CYC;
                    end else if (cnt == 5'h0) begin
                        state <= LCC_IDLE;
                    end else begin
                        cnt <= cnt - 5'h1;
                    end
                end
                default: begin
                    state <= LCC_INIT;
                    cnt   <= LCC_INIT_CYC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration bits; pin and command both restore defaults
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            display_on_bit    <= 1'b0;
            inverse_bit       <= 1'b0;
            all_pixels_on_bit <= 1'b0;
            column_flip       <= 1'b0;
            row_flip          <= 1'b0;
            ext_set           <= 1'b0;
            sleep_state       <= 1'b1;
        end else if (cfg_clear) begin
            display_on_bit    <= 1'b0;
            inverse_bit       <= 1'b0;
            all_pixels_on_bit <= 1'b0;
            column_flip       <= 1'b0;
            row_flip          <= 1'b0;
            ext_set           <= 1'b0;
            sleep_state       <= 1'b1;
        end else if (wr_disp && avs_byteenable[0]) begin
            inverse_bit       <= avs_writedata[LCC_DS_INV];
            all_pixels_on_bit <= avs_writedata[LCC_DS_DAL];
            // Display-on only lands once all-pixels-on is active
            if (all_pixels_on_bit || avs_writedata[LCC_DS_DAL]) begin
                display_on_bit <= avs_writedata[LCC_DS_DON];
            end
            column_flip <= avs_writedata[LCC_DS_CFLIP];
            row_flip    <= avs_writedata[LCC_DS_RFLIP];
            ext_set     <= avs_writedata[LCC_DS_EXTSET];
            if (avs_writedata[LCC_DS_SLEEP]) begin
                sleep_state <= 1'b1;
            end else if (avs_writedata[LCC_DS_WAKE]) begin
                sleep_state <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clock_source_run <= 1'b0;
            mult_basic       <= LCC_RST_MULT_B;
            mult_ext         <= LCC_RST_MULT_E;
            vlcd_level_code  <= LCC_RST_VL;
            vlcd_level_shift <= LCC_RST_VS;
        end else if (cfg_clear) begin
            clock_source_run <= 1'b0;
            mult_basic       <= LCC_RST_MULT_B;
            mult_ext         <= LCC_RST_MULT_E;
            vlcd_level_code  <= LCC_RST_VL;
            vlcd_level_shift <= LCC_RST_VS;
        end else if (wr_pow) begin
            clock_source_run <= avs_writedata[LCC_PW_OSC];
            mult_basic       <= avs_writedata[LCC_PW_MB +: 2];
            mult_ext         <= avs_writedata[LCC_PW_ME +: 3];
            vlcd_level_code  <= avs_writedata[LCC_PW_VL +: 6];
            vlcd_level_shift <= avs_writedata[LCC_PW_VS +: 3];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            picture_rate_sel <= LCC_RST_FR;
            temp_slope_sel   <= LCC_RST_TC;
            vert_addr        <= 1'b0;
            byte_flip_sel    <= 1'b0;
            symbol_line_en   <= 1'b0;
            lower_lines_flip <= 1'b0;
            row_group_sel    <= 1'b0;
            ext_clock_sel    <= 1'b0;
        end else if (cfg_clear) begin
            picture_rate_sel <= LCC_RST_FR;
            temp_slope_sel   <= LCC_RST_TC;
            vert_addr        <= 1'b0;
            byte_flip_sel    <= 1'b0;
            symbol_line_en   <= 1'b0;
            lower_lines_flip <= 1'b0;
            row_group_sel    <= 1'b0;
            ext_clock_sel    <= 1'b0;
        end else if (wr_ext) begin
            picture_rate_sel <= avs_writedata[LCC_EX_FR +: 2];
            temp_slope_sel   <= avs_writedata[LCC_EX_TC +: 3];
            vert_addr        <= avs_writedata[LCC_EX_VERT];
            byte_flip_sel    <= avs_writedata[LCC_EX_BYTE];
            symbol_line_en   <= avs_writedata[LCC_EX_SYM];
            lower_lines_flip <= avs_writedata[LCC_EX_LOWER];
            row_group_sel    <= avs_writedata[LCC_EX_RGRP];
            ext_clock_sel    <= avs_writedata[LCC_EX_EXTCLK];
        end
    end

    // ------------------------------------------------------------
    // Display mode decode
    // ------------------------------------------------------------
    always_comb begin
        if (sleep_state) begin
            mode = LCC_DM_OFF;
        end else if (!clock_source_run) begin
            mode = LCC_DM_OSC_OFF;
        end else if (!all_pixels_on_bit) begin
            mode = display_on_bit ? (inverse_bit ? LCC_DM_INVERSE
                                                 : LCC_DM_NORMAL)
                                  : LCC_DM_OSC_ON;
        end else if (!display_on_bit) begin
            mode = LCC_DM_OFF;
        end else begin
            mode = LCC_DM_ALL_ON;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outputs_low   <= 1'b1;
            generators_on <= 1'b0;
            oscillator_on <= 1'b0;
            inverse_out   <= 1'b0;
            all_on_out    <= 1'b0;
            mult_factor   <= 3'h4;
            rows_at_once  <= 3'h0;
        end else begin
            outputs_low   <= !lcc_drives(mode);
            generators_on <= lcc_drives(mode);
            oscillator_on <= (mode != LCC_DM_OFF)
                             && (mode != LCC_DM_OSC_OFF);
            inverse_out   <= (mode == LCC_DM_INVERSE);
            all_on_out    <= (mode == LCC_DM_ALL_ON);
            mult_factor   <= lcc_mult(ext_set, mult_basic, mult_ext);
            // Zero means automatic from multiplex ratio
            rows_at_once  <= row_group_sel ? 3'h4 : 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Column mapping; RAM keeps data while asleep
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ram_col_out <= 7'h00;
        end else if (ram_wr) begin
            // Only new writes move; old image stays until rewritten
            ram_col_out <= column_flip ? 7'h7F - ram_col_in
                                       : ram_col_in;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0;
        case (avs_address)
            LCC_OFF_STATUS: begin
                next_rdata[LCC_ST_BUSY]     = busy;
                next_rdata[LCC_ST_DON]      = display_on_bit;
                next_rdata[LCC_ST_RESIP]    = (state == LCC_INIT);
                next_rdata[LCC_ST_MF +: 3]  = LCC_MAKER;
                next_rdata[LCC_ST_ROWS]     = ROWS80;
            end
            LCC_OFF_DISPLAY: begin
                next_rdata[LCC_DS_DON]    = display_on_bit;
                next_rdata[LCC_DS_INV]    = inverse_bit;
                next_rdata[LCC_DS_DAL]    = all_pixels_on_bit;
                next_rdata[LCC_DS_CFLIP]  = column_flip;
                next_rdata[LCC_DS_RFLIP]  = row_flip;
                next_rdata[LCC_DS_EXTSET] = ext_set;
                next_rdata[LCC_DS_SLEEP]  = sleep_state;
            end
            LCC_OFF_POWER: begin
                next_rdata[LCC_PW_OSC]     = clock_source_run;
                next_rdata[LCC_PW_MB +: 2] = mult_basic;
                next_rdata[LCC_PW_ME +: 3] = mult_ext;
                next_rdata[LCC_PW_VL +: 6] = vlcd_level_code;
                next_rdata[LCC_PW_VS +: 3] = vlcd_level_shift;
            end
            LCC_OFF_EXT: begin
                next_rdata[LCC_EX_FR +: 2]  = picture_rate_sel;
                next_rdata[LCC_EX_TC +: 3]  = temp_slope_sel;
                next_rdata[LCC_EX_VERT]     = vert_addr;
                next_rdata[LCC_EX_BYTE]     = byte_flip_sel;
                next_rdata[LCC_EX_SYM]      = symbol_line_en;
                next_rdata[LCC_EX_LOWER]    = lower_lines_flip;
                next_rdata[LCC_EX_RGRP]     = row_group_sel;
                next_rdata[LCC_EX_EXTCLK]   = ext_clock_sel;
            end
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_rdata;
        end
    end
endmodule // lcc_config

// [src/lcc_pkg.sv]
package lcc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] LCC_OFF_STATUS  = 4'h0;
    localparam logic [3:0] LCC_OFF_DISPLAY = 4'h4;
    localparam logic [3:0] LCC_OFF_POWER   = 4'h8;
    localparam logic [3:0] LCC_OFF_EXT     = 4'hC;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LCC_ST_BUSY   = 7;
    localparam int LCC_ST_DON    = 5;
    localparam int LCC_ST_RESIP  = 4;
    localparam int LCC_ST_MF     = 1;
    localparam int LCC_ST_ROWS   = 0;
    localparam int LCC_DS_DON    = 0;
    localparam int LCC_DS_INV    = 1;
    localparam int LCC_DS_DAL    = 2;
    localparam int LCC_DS_CFLIP  = 3;
    localparam int LCC_DS_RFLIP  = 4;
    localparam int LCC_DS_EXTSET = 5;
    localparam int LCC_DS_RESET  = 6;
    localparam int LCC_DS_SLEEP  = 7;
    localparam int LCC_DS_WAKE   = 8;
    localparam int LCC_PW_OSC    = 0;
    localparam int LCC_PW_MB     = 4;
    localparam int LCC_PW_ME     = 8;
    localparam int LCC_PW_VL     = 12;
    localparam int LCC_PW_VS     = 20;
    localparam int LCC_EX_FR     = 0;
    localparam int LCC_EX_TC     = 4;
    localparam int LCC_EX_VERT   = 8;
    localparam int LCC_EX_BYTE   = 9;
    localparam int LCC_EX_SYM    = 10;
    localparam int LCC_EX_LOWER  = 11;
    localparam int LCC_EX_RGRP   = 12;
    localparam int LCC_EX_EXTCLK = 13;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] LCC_RST_MULT_B = 2'h0;
    localparam logic [2:0] LCC_RST_MULT_E = 3'h4;
    localparam logic [1:0] LCC_RST_FR     = 2'h3;
    localparam logic [2:0] LCC_RST_TC     = 3'h2;
    localparam logic [5:0] LCC_RST_VL     = 6'h00;
    localparam logic [2:0] LCC_RST_VS     = 3'h0;
    // Arbitrary maker code, neutral value
    localparam logic [2:0] LCC_MAKER      = 3'h5;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         LCC_INIT_NS    = 64;
    localparam int         LCC_CLK_NS     = 4;
    localparam logic [4:0] LCC_INIT_CYC   =
        5'((LCC_INIT_NS + LCC_CLK_NS - 1) / LCC_CLK_NS);
    localparam logic [2:0] LCC_BUSY_CYC   = 3'h3;

    typedef enum logic [1:0] {
        LCC_IDLE,
        LCC_INIT,
        LCC_BUSY
    } lcc_state_t;

    typedef enum logic [2:0] {
        LCC_DM_OSC_OFF,
        LCC_DM_OSC_ON,
        LCC_DM_OFF,
        LCC_DM_NORMAL,
        LCC_DM_INVERSE,
        LCC_DM_ALL_ON
    } lcc_mode_t;
endpackage

// [tb/lcc_config_sva.sv]
`timescale 1ns/100ps
module lcc_config_chk
    import lcc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       init_pulse_n,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       ram_wr,
    input wire logic [6:0] ram_col_in,
    input wire logic [6:0] ram_col_out,
    input wire logic       outputs_low,
    input wire logic       generators_on,
    input wire logic       oscillator_on,
    input wire logic       inverse_out,
    input wire logic       all_on_out,
    input wire logic [2:0] mult_factor,
    input wire logic [1:0] picture_rate_sel,
    input wire logic [2:0] temp_slope_sel,
    input wire logic [2:0] rows_at_once,
    input wire logic       ext_clock_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Bus answer and reset state
    // ------------------------------------------------------------
    ack_delay_a: assert property (($rose(avs_read) || $rose(avs_write))
        |=> !avs_waitrequest) else $error("No ack one cycle after request");
    ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Ack held longer than one cycle");
    reset_state_a: assert property ($rose(rstn) |-> outputs_low
        && !oscillator_on && mult_factor == 3'h4
        && picture_rate_sel == LCC_RST_FR && temp_slope_sel == LCC_RST_TC)
        else $error("Wrong state after reset release");
    // Pin is synchronised, so allow a few cycles for defaults to land
    init_pin_a: assert property ($fell(init_pulse_n) |-> ##[1:4]
        (picture_rate_sel == LCC_RST_FR && temp_slope_sel == LCC_RST_TC
        && rows_at_once == 3'h0 && !ext_clock_sel))
        else $error("Init pin did not restore defaults");
    // ------------------------------------------------------------
    // Display modes and mapping
    // ------------------------------------------------------------
    all_on_prio_a: assert property (all_on_out |-> !inverse_out)
        else $error("Inverse shown while all pixels on");
    pads_gen_a: assert property (outputs_low |-> !generators_on)
        else $error("Generators on with pads low");
    gen_osc_a: assert property (generators_on |-> oscillator_on)
        else $error("Generators on without oscillator");
    mult_range_a: assert property (mult_factor >= 3'h2
        && mult_factor <= 3'h7) else $error("Multiplier out of range");
    row_group_a: assert property (rows_at_once == 3'h0
        || rows_at_once == 3'h4) else $error("Bad row group count");
    col_map_a: assert property (ram_wr |=> (ram_col_out ==
        $past(ram_col_in) || ram_col_out == 7'h7F - $past(ram_col_in)))
        else $error("Column mapping wrong");
    cover property (all_on_out);
    cover property (inverse_out);
    cover property ($fell(init_pulse_n));
    cover property (ram_wr ##1 ram_col_out != $past(ram_col_in));
endmodule // lcc_config_chk

// [tb/lcc_host.sv]
`timescale 1ns/100ps
module lcc_host
    import lcc_pkg::*;
(
    input  wire logic        clk,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end
    // Extra edge after release keeps strobes from toggling in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wt;
        logic [31:0] s;
        s = 32'hFFFF_FFFF;
        while (s[LCC_ST_BUSY] !== 1'b0) rd(LCC_OFF_STATUS, s);
    endtask
endmodule // lcc_host

// [tb/tb.sv]
`timescale 1ns/100ps
bind lcc_config lcc_config_chk u_chk (.*);
module tb;
    import lcc_pkg::*;
    typedef struct packed {
        logic [3:0]  a;
        logic [31:0] d;
        logic [11:0] e;
    } lcc_row_t;
    localparam logic [11:0] DEF = {3'h4, LCC_RST_FR, LCC_RST_TC, 4'h0};
    logic        clk, rstn, init_pulse_n, ram_wr;
    logic [6:0]  ram_col_in, ram_col_out;
    logic [3:0]  avs_address, avs_byteenable;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, r;
    logic        outputs_low, generators_on, oscillator_on;
    logic        inverse_out, all_on_out, ext_clock_sel;
    logic [2:0]  mult_factor, temp_slope_sel, rows_at_once;
    logic [1:0]  picture_rate_sel;
    lcc_row_t    rows [21];
    int          bad_count, samples_checked;
    wire  [11:0] cfg = {mult_factor, picture_rate_sel, temp_slope_sel,
                        rows_at_once, ext_clock_sel};
    lcc_config uut (.*);
    lcc_host   hst (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task done(input string s);
        $display("test %s done", s);
    endtask
    task ram(input logic [6:0] c);
        ram_col_in <= c;
        ram_wr     <= 1'b1;
        @(posedge clk);
        ram_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task finish_test;
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        init_pulse_n = 1'b1;
        ram_wr = 1'b0;
        ram_col_in = 7'h00;
        for (int i = 0; i < 8; i++) begin
            rows[i] = '{LCC_OFF_EXT,
                32'((i << 4) | (i & 3) | (i == 7 ? 32'h3000 : 32'h0)),
                {3'h4, 2'(i), 3'(i), (i == 7) ? 3'h4 : 3'h0, i == 7}};
            rows[13+i] = '{LCC_OFF_POWER, 32'(i << 8),
                {3'(i < 4 ? i + 2 : i), 2'h3, 3'h7, 3'h4, 1'b1}};
        end
        for (int i = 0; i < 4; i++)
            rows[8+i] = '{LCC_OFF_POWER, 32'(i << 4),
                {3'(4 + i), 2'h3, 3'h7, 3'h4, 1'b1}};
        rows[12] = '{LCC_OFF_DISPLAY, 32'h20, {3'h2, 2'h3, 3'h7, 4'h9}};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        hst.rd(LCC_OFF_STATUS, r);
        chk(r[7:0], {4'h9, LCC_MAKER, 1'b1});
        hst.wt();
        hst.rd(LCC_OFF_STATUS, r);
        chk(r[7:0], {4'h0, LCC_MAKER, 1'b1});
        chk(cfg, DEF);
        hst.rd(LCC_OFF_DISPLAY, r);
        chk({r[7:0], outputs_low, oscillator_on}, 10'h202);
        hst.rd(LCC_OFF_POWER, r);
        chk(r, 32'h400);
        hst.rd(LCC_OFF_EXT, r);
        chk(r, 32'h23);
        hst.rd(4'h2, r);
        chk(r, 32'h0);
        done("reset");
        foreach (rows[i]) begin
            hst.wr(rows[i].a, rows[i].d);
            hst.wt();
            chk(cfg, rows[i].e);
        end
        done("table");
        // Second write lands inside the busy window and must be dropped
        hst.wr(LCC_OFF_EXT, 32'h0);
        hst.wr(LCC_OFF_EXT, 32'h3);
        hst.wt();
        chk(picture_rate_sel, 2'h0);
        hst.wr(LCC_OFF_DISPLAY, 32'h121);
        hst.wt();
        hst.rd(LCC_OFF_STATUS, r);
        chk(r[LCC_ST_DON], 1'b0);
        chk({oscillator_on, outputs_low}, 2'h1);
        hst.wr(LCC_OFF_POWER, 32'h1);
        hst.wt();
        chk({oscillator_on, generators_on}, 2'h2);
        hst.wr(LCC_OFF_DISPLAY, 32'h27);
        hst.wt();
        chk({all_on_out, inverse_out, outputs_low}, 3'h4);
        hst.rd(LCC_OFF_STATUS, r);
        chk(r[LCC_ST_DON], 1'b1);
        hst.wr(LCC_OFF_DISPLAY, 32'h23);
        hst.wt();
        chk({all_on_out, inverse_out}, 2'h1);
        hst.wr(LCC_OFF_DISPLAY, 32'h21);
        hst.wt();
        chk({inverse_out, outputs_low, generators_on}, 3'h1);
        hst.wr(LCC_OFF_DISPLAY, 32'h24);
        hst.wt();
        chk({outputs_low, oscillator_on, generators_on}, 3'h4);
        hst.wr(LCC_OFF_DISPLAY, 32'hA3);
        hst.wt();
        chk({outputs_low, oscillator_on, inverse_out}, 3'h4);
        hst.rd(LCC_OFF_DISPLAY, r);
        chk(r[LCC_DS_SLEEP], 1'b1);
        done("display");
        ram(7'h05);
        chk(ram_col_out, 7'h05);
        hst.wr(LCC_OFF_DISPLAY, 32'hA8);
        hst.wt();
        ram(7'h05);
        chk(ram_col_out, 7'h7A);
        done("column");
        hst.wr(LCC_OFF_EXT, 32'h3F00);
        hst.wt();
        hst.rd(LCC_OFF_EXT, r);
        chk(r, 32'h3F00);
        hst.wr(LCC_OFF_POWER, 32'h73F000);
        hst.wt();
        hst.rd(LCC_OFF_POWER, r);
        chk(r, 32'h73F000);
        hst.wr(LCC_OFF_DISPLAY, 32'h40);
        hst.rd(LCC_OFF_STATUS, r);
        chk(r[LCC_ST_RESIP], 1'b1);
        hst.wt();
        chk(cfg, DEF);
        hst.rd(LCC_OFF_POWER, r);
        chk(r, 32'h400);
        hst.rd(LCC_OFF_DISPLAY, r);
        chk(r[7:0], 8'h80);
        done("command reset");
        hst.wr(LCC_OFF_EXT, 32'h3000);
        hst.wt();
        init_pulse_n <= 1'b0;
        repeat (3) @(posedge clk);
        init_pulse_n <= 1'b1;
        hst.wt();
        chk(cfg, DEF);
        hst.rd(LCC_OFF_EXT, r);
        chk(r, 32'h23);
        done("init pin");
        hst.wr(LCC_OFF_EXT, 32'h3001);
        hst.wt();
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        hst.rd(LCC_OFF_STATUS, r);
        chk(r[7:0], {4'h9, LCC_MAKER, 1'b1});
        chk(cfg, DEF);
        hst.wt();
        done("mid reset");
        finish_test();
    end
endmodule // tb
